// >>> logic/tmi_defines.vh
`ifndef TMI_DEFINES_VH
`define TMI_DEFINES_VH
// register offsets
`define TMI_OFS_MAINT       8'h6C
`define TMI_OFS_LOOP_CTRL   8'h74
`define TMI_OFS_LOOP_PAT    8'h75
`define TMI_OFS_REPORT_CTRL 8'h7F
`define TMI_OFS_BOM_CODE    8'h80
`define TMI_OFS_MODE        8'h81
`define TMI_OFS_STATUS      8'h82
// maintenance field positions
`define TMI_MT_ONES   0
`define TMI_MT_ZEROS  1
`define TMI_MT_SHIFT  2
// loop code control field positions
`define TMI_LC_LEN_LO 0
`define TMI_LC_EN     2
`define TMI_LC_UNFM   3
// report control field positions
`define TMI_RC_AUTO   0
`define TMI_RC_CR     1
`define TMI_RC_R      2
`define TMI_RC_U1     3
`define TMI_RC_U2     4
`define TMI_RC_LB     5
// mode field positions
`define TMI_MD_T1     0
`define TMI_MD_ESF    1
// reset values
`define TMI_RST_BOM   8'h3F
`define TMI_RST_ZERO  8'h00
// stream geometry
`define TMI_FRAME_LAST 8'd192
`define TMI_MF_LAST    5'd23
`define TMI_FRAMES_SEC 8000
// report layout
`define TMI_FLAG      8'h7E
`define TMI_SAPI      8'h38
`define TMI_TEI       8'h01
`define TMI_CTRL      8'h03
`define TMI_REP_BODY  7'd96
`define TMI_REP_LAST  7'd111
`define TMI_CRC_INIT  16'hFFFF
`define TMI_CRC_POLY  16'h8408
// bit message layout
`define TMI_BOM_ONES  4'd8
`define TMI_BOM_CODE0 4'd9
`define TMI_BOM_LAST  4'd15
`endif

// >>> logic/tmi_top.v
`include "tmi_defines.vh"
`default_nettype none
module tmi_top #(
    parameter FRAMES_PER_SEC = `TMI_FRAMES_SEC
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // incoming transmit stream
    input  wire       tx_valid,
    input  wire       tx_bit,
    input  wire       tx_mf_start,
    // per-second events
    input  wire       evt_line_viol,
    input  wire       evt_crc,
    input  wire       evt_fbit,
    input  wire       evt_fbit_severe,
    input  wire       evt_slip,
    // outgoing line stream
    output reg        line_valid,
    output reg        line_bit
);

    // software registers
    reg  [7:0]  maint_ctrl;        // all ones, all zeros, shift toggle
    reg  [7:0]  loop_code_control; // length, enable, unframed
    reg  [7:0]  loop_code_pattern_reg;
    reg  [7:0]  perf_report_control;
    reg  [7:0]  bit_message_code_reg;
    reg  [7:0]  mode_ctrl;         // T1 and superframe selection
    // stream position
    reg  [7:0]  frame_pos;         // bit within frame, 0 = framing bit
    reg  [4:0]  frame_num;         // frame within multiframe
    reg  [13:0] sec_frames;        // frames in current second
    // event counters
    reg  [9:0]  crc_cnt;           // saturating CRC-6 count
    reg         lv_seen;
    reg         fe_seen;
    reg         se_seen;
    reg         sl_seen;
    // report engine
    reg  [95:0] report_data;       // octets 1..12, bit 1 in lsb
    reg  [6:0]  rep_idx;           // bit index 0..111
    reg         rep_busy;
    reg  [15:0] rep_crc;           // running frame check
    reg  [1:0]  seq_cnt;           // modulo-4 sequence
    // bit message and loop code
    reg  [3:0]  bom_ptr;
    reg  [2:0]  loop_ptr;
    // frame shift
    reg         shift_prev;
    reg         del_pend;
    reg         rep_pend;
    reg  [7:0]  lfsr;              // random choice source

    // decoded control
    wire        t1_esf    = mode_ctrl[`TMI_MD_T1] & mode_ctrl[`TMI_MD_ESF];
    wire        t1_mode   = mode_ctrl[`TMI_MD_T1];
    wire [5:0]  bit_message_code = bit_message_code_reg[5:0];
    wire        bom_on    = t1_esf & (bit_message_code != 6'h3F);
    wire        loop_on   = t1_mode & loop_code_control[`TMI_LC_EN];
    wire        loop_unfm = loop_code_control[`TMI_LC_UNFM];
    wire [1:0]  loop_code_length = loop_code_control[1:0];
    wire [3:0]  loop_last = {2'b00, loop_code_length} + 4'd5; // 5..8 bits
    wire        shift_tog = maint_ctrl[`TMI_MT_SHIFT];

    // position of the bit now offered
    wire [7:0]  cur_pos   = tx_mf_start ? 8'd0 : frame_pos;
    wire [4:0]  cur_num   = tx_mf_start ? 5'd0 : frame_num;
    wire        frame_end = tx_valid & (cur_pos == `TMI_FRAME_LAST);
    wire        sec_tick  = frame_end & (sec_frames == FRAMES_PER_SEC[13:0] - 14'd1);
    // data-link bit: framing bit of every other frame
    wire        dl_slot   = t1_esf & tx_valid & (cur_pos == 8'd0) & ~cur_num[0];

    // report bit and its frame check
    wire        rep_in_body = rep_idx < `TMI_REP_BODY;
    wire [6:0]  fcs_idx     = rep_idx - `TMI_REP_BODY;
    wire        rep_bit     = rep_in_body ? report_data[rep_idx]
                                          : ~rep_crc[fcs_idx[3:0]];
    wire        crc_fb      = rep_crc[0] ^ rep_bit;

    // bit message sequence
    wire [3:0]  bom_cidx = bom_ptr - `TMI_BOM_CODE0;
    reg         bom_bit;
    // loop code bit, sent msb of the active length first
    wire [3:0]  loop_sel = loop_last - 4'd1 - {1'b0, loop_ptr};
    wire        loop_bit = loop_code_pattern_reg[loop_sel[2:0]];
    wire        loop_hit = loop_on & (loop_unfm | (cur_pos != 8'd0));

    // count including an event that lands in the tick cycle
    wire [9:0]  crc_now = crc_cnt + {9'h000, evt_crc & (crc_cnt != 10'h3FF)};
    // CRC-6 bins
    wire        g1 = (crc_now == 10'd1);
    wire        g2 = (crc_now >= 10'd2)   & (crc_now <= 10'd5);
    wire        g3 = (crc_now >= 10'd6)   & (crc_now <= 10'd10);
    wire        g4 = (crc_now >= 10'd11)  & (crc_now <= 10'd100);
    wire        g5 = (crc_now >= 10'd101) & (crc_now <= 10'd319);
    wire        g6 = (crc_now > 10'd320);
    // event octet pair
    wire [1:0]  next_seq = seq_cnt + 2'd1;
    wire [7:0]  odd_oct  = {g3, lv_seen | evt_line_viol, g4,
                            perf_report_control[`TMI_RC_U1],
                            perf_report_control[`TMI_RC_U2],
                            g5, sl_seen | evt_slip, g6};
    wire [7:0]  even_oct = {fe_seen | evt_fbit, se_seen | evt_fbit_severe,
                            perf_report_control[`TMI_RC_LB], g1,
                            perf_report_control[`TMI_RC_R], g2,
                            next_seq};
    wire [7:0]  sapi_oct = `TMI_SAPI |
                           {6'h00, perf_report_control[`TMI_RC_CR], 1'b0};
    wire [15:0] pair     = {even_oct, odd_oct};

    // bit message pattern lookup
    always @* begin
        if (bom_ptr < `TMI_BOM_ONES) begin
            bom_bit = 1'b1;
        end else if ((bom_ptr >= `TMI_BOM_CODE0) && (bom_ptr < `TMI_BOM_LAST)) begin
            bom_bit = bit_message_code[bom_cidx[2:0]];
        end else begin
            bom_bit = 1'b0;
        end
    end

    // processed bit, overrides in order
    reg next_bit;
    always @* begin
        next_bit = tx_bit;
        if (dl_slot && rep_busy) begin
            next_bit = rep_bit;
        end else if (dl_slot && bom_on) begin
            next_bit = bom_bit;
        end
        if (loop_hit) begin
            next_bit = loop_bit;
        end
        // final override, zeros first
        if (maint_ctrl[`TMI_MT_ZEROS]) begin
            next_bit = 1'b0;
        end else if (maint_ctrl[`TMI_MT_ONES]) begin
            next_bit = 1'b1;
        end
    end

    // register writes
    always @(posedge core_clk) begin
        if (reset) begin
            maint_ctrl            <= `TMI_RST_ZERO;
            loop_code_control     <= `TMI_RST_ZERO;
            loop_code_pattern_reg <= `TMI_RST_ZERO;
            perf_report_control   <= `TMI_RST_ZERO;
            bit_message_code_reg  <= `TMI_RST_BOM;
            mode_ctrl             <= `TMI_RST_ZERO;
        end else if (reg_wr) begin
            case (reg_addr)
                `TMI_OFS_MAINT:       maint_ctrl            <= reg_wdata;
                `TMI_OFS_LOOP_CTRL:   loop_code_control     <= reg_wdata;
                `TMI_OFS_LOOP_PAT:    loop_code_pattern_reg <= reg_wdata;
                `TMI_OFS_REPORT_CTRL: perf_report_control   <= reg_wdata;
                `TMI_OFS_BOM_CODE:    bit_message_code_reg  <= reg_wdata;
                `TMI_OFS_MODE:        mode_ctrl             <= reg_wdata;
                default: begin
                    // unmapped write ignored
                end
            endcase
        end
    end

    // register reads, data one cycle later
    always @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TMI_OFS_MAINT:       reg_rdata <= maint_ctrl;
                `TMI_OFS_LOOP_CTRL:   reg_rdata <= loop_code_control;
                `TMI_OFS_LOOP_PAT:    reg_rdata <= loop_code_pattern_reg;
                `TMI_OFS_REPORT_CTRL: reg_rdata <= perf_report_control;
                `TMI_OFS_BOM_CODE:    reg_rdata <= bit_message_code_reg;
                `TMI_OFS_MODE:        reg_rdata <= mode_ctrl;
                `TMI_OFS_STATUS:      reg_rdata <= {5'h00, rep_busy, seq_cnt};
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // stream position and second counter
    always @(posedge core_clk) begin
        if (reset) begin
            frame_pos  <= 8'd0;
            frame_num  <= 5'd0;
            sec_frames <= 14'd0;
        end else if (tx_valid) begin
            if (cur_pos == `TMI_FRAME_LAST) begin
                frame_pos <= 8'd0;
                frame_num <= (cur_num == `TMI_MF_LAST) ? 5'd0 : cur_num + 5'd1;
            end else begin
                frame_pos <= cur_pos + 8'd1;
                frame_num <= cur_num;
            end
            // one second of frames
            if (sec_tick) begin
                sec_frames <= 14'd0;
            end else if (frame_end) begin
                sec_frames <= sec_frames + 14'd1;
            end
        end
    end

    // event counting, restarted at each second
    always @(posedge core_clk) begin
        if (reset) begin
            crc_cnt <= 10'd0;
            lv_seen <= 1'b0;
            fe_seen <= 1'b0;
            se_seen <= 1'b0;
            sl_seen <= 1'b0;
        end else if (sec_tick) begin
            // events were folded into any report built this tick, start clean
            crc_cnt <= 10'd0;
            lv_seen <= 1'b0;
            fe_seen <= 1'b0;
            se_seen <= 1'b0;
            sl_seen <= 1'b0;
        end else begin
            if (evt_crc && (crc_cnt != 10'h3FF)) begin
                crc_cnt <= crc_cnt + 10'd1;
            end
            lv_seen <= lv_seen | evt_line_viol;
            fe_seen <= fe_seen | evt_fbit;
            se_seen <= se_seen | evt_fbit_severe;
            sl_seen <= sl_seen | evt_slip;
        end
    end

    // report build and serial send
    always @(posedge core_clk) begin
        if (reset) begin
            report_data <= 96'h0;
            rep_idx     <= 7'd0;
            rep_busy    <= 1'b0;
            rep_crc     <= `TMI_CRC_INIT;
            seq_cnt     <= 2'd0;
        end else if (sec_tick && perf_report_control[`TMI_RC_AUTO] && t1_esf) begin
            // octets 1..12 laid out octet 1 lowest
            report_data <= {pair, pair, pair, pair, `TMI_CTRL, `TMI_TEI,
                            sapi_oct, `TMI_FLAG};
            rep_idx     <= 7'd0;
            rep_busy    <= 1'b1;
            rep_crc     <= `TMI_CRC_INIT;
            seq_cnt     <= next_seq;
        end else if (dl_slot && rep_busy) begin
            // frame check over octets 2..12
            if (rep_in_body && (rep_idx >= 7'd8)) begin
                rep_crc <= (rep_crc >> 1) ^ (crc_fb ? `TMI_CRC_POLY : 16'h0000);
            end
            if (rep_idx == `TMI_REP_LAST) begin
                rep_busy <= 1'b0;
            end
            rep_idx <= rep_idx + 7'd1;
        end else if (!t1_esf) begin
            rep_busy <= 1'b0;
        end
    end

    // bit message pointer, repeats while enabled
    always @(posedge core_clk) begin
        if (reset) begin
            bom_ptr <= 4'd0;
        end else if (!bom_on) begin
            bom_ptr <= 4'd0;
        end else if (dl_slot && !rep_busy) begin
            bom_ptr <= bom_ptr + 4'd1;
        end
    end

    // loop code pointer over the overwritten bits
    always @(posedge core_clk) begin
        if (reset) begin
            loop_ptr <= 3'd0;
        end else if (!loop_on) begin
            loop_ptr <= 3'd0;
        end else if (tx_valid && loop_hit) begin
            if ({1'b0, loop_ptr} >= loop_last - 4'd1) begin
                loop_ptr <= 3'd0;
            end else begin
                loop_ptr <= loop_ptr + 3'd1;
            end
        end
    end

    // random source for the shift choice
    always @(posedge core_clk) begin
        if (reset) begin
            lfsr <= 8'h01;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    // shift toggle edges arm a delete or a repeat
    always @(posedge core_clk) begin
        if (reset) begin
            shift_prev <= 1'b0;
            del_pend   <= 1'b0;
            rep_pend   <= 1'b0;
        end else begin
            shift_prev <= shift_tog;
            if (shift_tog != shift_prev) begin
                // either edge counts
                if (lfsr[0]) begin
                    del_pend <= 1'b1;
                end else begin
                    rep_pend <= 1'b1;
                end
            end else begin
                if (tx_valid) begin
                    del_pend <= 1'b0;
                end
                if (!tx_valid) begin
                    rep_pend <= 1'b0;
                end
            end
        end
    end

    // output stage
    always @(posedge core_clk) begin
        if (reset) begin
            line_valid <= 1'b0;
            line_bit   <= 1'b0;
        end else if (tx_valid) begin
            // a pending delete swallows this bit
            line_valid <= ~del_pend;
            // a deleted bit leaves the held line bit alone
            if (!del_pend) begin
                line_bit <= next_bit;
            end
        end else begin
            // a pending repeat resends the last bit in a gap
            line_valid <= rep_pend;
        end
    end

endmodule
`default_nettype wire

// >>> bench/tmi_top_assertions.sv
`include "tmi_defines.vh"
`default_nettype none
module tmi_chk #(
    parameter FRAMES_PER_SEC = 8000
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // incoming stream and events
    input wire logic       tx_valid,
    input wire logic       tx_bit,
    input wire logic       tx_mf_start,
    input wire logic       evt_line_viol,
    input wire logic       evt_crc,
    input wire logic       evt_fbit,
    input wire logic       evt_fbit_severe,
    input wire logic       evt_slip,
    // outgoing stream
    input wire logic       line_valid,
    input wire logic       line_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] mt;  // maintenance shadow
    logic [1:0] md;  // mode shadow
    logic [3:0] lc;  // loop control shadow
    logic [7:0] pat; // loop pattern shadow
    logic       shf; // a frame shift was asked for
    // shadow the registers the properties depend on
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mt  <= 3'h0;
            md  <= 2'h0;
            lc  <= 4'h0;
            pat <= 8'h00;
            shf <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `TMI_OFS_MAINT) begin
                mt  <= reg_wdata[2:0];
                shf <= shf | (reg_wdata[2] != mt[2]);
            end
            if (reg_addr == `TMI_OFS_MODE) md <= reg_wdata[1:0];
            if (reg_addr == `TMI_OFS_LOOP_CTRL) lc <= reg_wdata[3:0];
            if (reg_addr == `TMI_OFS_LOOP_PAT) pat <= reg_wdata;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // an input bit and its forwarded copy one cycle later
    sequence s_req; tx_valid && !shf; endsequence
    sequence s_out; ##1 line_valid; endsequence
    property p_latency; s_req |-> s_out; endproperty
    a_latency: assert property (p_latency) else $error("input bit not forwarded");
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_maint; reg_rd && reg_addr == `TMI_OFS_MAINT |=> reg_rdata[2:0] == mt; endproperty
    a_rd_maint: assert property (p_rd_maint) else $error("maintenance readback wrong");
    property p_zeros; tx_valid && mt[1] |=> !line_valid || !line_bit; endproperty
    a_zeros: assert property (p_zeros) else $error("one sent while zeros forced");
    property p_ones; tx_valid && mt[0] && !mt[1] |=> !line_valid || line_bit; endproperty
    a_ones: assert property (p_ones) else $error("zero sent while ones forced");
    property p_repeat; line_valid && !$past(tx_valid) |-> $stable(line_bit); endproperty
    a_repeat: assert property (p_repeat) else $error("repeated bit differs");
    property p_hold; !line_valid |-> $stable(line_bit); endproperty
    a_hold: assert property (p_hold) else $error("line bit moved without valid");
    property p_transparent;
        tx_valid && !md[0] && mt[1:0] == 2'b00 && !shf |=> line_valid && line_bit == $past(tx_bit);
    endproperty
    a_transparent: assert property (p_transparent) else $error("stream altered");
    property p_unframed;
        tx_valid && md == 2'b01 && lc == 4'hF && pat == 8'hFF && mt[1:0] == 2'b00
            |=> !line_valid || line_bit;
    endproperty
    a_unframed: assert property (p_unframed) else $error("loop code bit lost");
endmodule
bind tmi_top tmi_chk #(.FRAMES_PER_SEC(FRAMES_PER_SEC)) u_chk (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_bit(tx_bit), .tx_mf_start(tx_mf_start), .evt_line_viol(evt_line_viol),
    .evt_crc(evt_crc), .evt_fbit(evt_fbit), .evt_fbit_severe(evt_fbit_severe),
    .evt_slip(evt_slip), .line_valid(line_valid), .line_bit(line_bit)
);
`default_nettype wire

// >>> bench/tmi_far_end.sv
`default_nettype none
module tmi_far_end (
    // clock and reset
    input  wire logic    core_clk,
    input  wire logic    reset,
    // received line and multiframe mark
    input  wire logic    line_valid,
    input  wire logic    line_bit,
    input  wire logic    mark,
    // recovered data-link bits and frame summary
    output logic [127:0] dl_hist,
    output logic [7:0]   ch_ones,
    output logic         f_last
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       mark_d; // mark lined up with the output bit
    logic [7:0] pos;    // bit index in the frame
    logic [4:0] frm;    // frame index in the multiframe
    logic [7:0] run;    // ones counted so far in the frame
    // follow the frame and collect what arrives
    always_ff @(posedge core_clk) begin
        mark_d <= mark;
        if (reset) begin
            pos     <= 8'h00;
            frm     <= 5'h00;
            run     <= 8'h00;
            dl_hist <= '0;
            ch_ones <= 8'h00;
            f_last  <= 1'b0;
        end else if (line_valid) begin
            if (mark_d || pos == 8'hC0) begin
                // framing bit opens a new frame
                frm     <= mark_d ? 5'h00 : frm + 5'h01;
                pos     <= 8'h00;
                f_last  <= line_bit;
                ch_ones <= run;
                run     <= 8'h00;
                // even frames carry the data link, oldest bit at the bottom
                if (mark_d || frm[0]) dl_hist <= {line_bit, dl_hist[127:1]};
            end else begin
                pos <= pos + 8'h01;
                run <= run + {7'h00, line_bit};
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tmi_top_tb.sv
`include "tmi_defines.vh"
`default_nettype none
module tmi_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic         core_clk = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         tx_valid = 1'b0;
    logic         tx_bit = 1'b0;
    logic         tx_mf_start = 1'b0;
    logic         ev_lv = 1'b0;
    logic         ev_crc = 1'b0;
    logic         ev_fb = 1'b0;
    logic         ev_fs = 1'b0;
    logic         ev_sl = 1'b0;
    logic [7:0]   reg_rdata, ch_ones, cyc, s;
    logic         line_valid, line_bit, f_last;
    logic [127:0] dl_hist;
    logic [4:0]   frm;
    logic [15:0]  v;
    logic [7:0]   ex [14];
    int           n_errors = 0;
    int           check_count = 0;
    int           n_in = 0;
    int           n_out = 0;
    int           d0;
    logic         f;
    // 4 ns clock
    always #2 core_clk = ~core_clk;
    tmi_top #(.FRAMES_PER_SEC(230)) dut (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
        .tx_bit(tx_bit), .tx_mf_start(tx_mf_start), .evt_line_viol(ev_lv), .evt_crc(ev_crc),
        .evt_fbit(ev_fb), .evt_fbit_severe(ev_fs), .evt_slip(ev_sl),
        .line_valid(line_valid), .line_bit(line_bit));
    tmi_far_end far (.core_clk(core_clk), .reset(reset), .line_valid(line_valid),
        .line_bit(line_bit), .mark(tx_valid && tx_mf_start), .dl_hist(dl_hist),
        .ch_ones(ch_ones), .f_last(f_last));
    // frame source: 193 bits then one idle cycle, odd channel bits set
    always @(posedge core_clk) begin
        n_in <= n_in + tx_valid;
        n_out <= n_out + line_valid;
        if (reset) begin
            cyc <= 8'h00;
            frm <= 5'h00;
            tx_valid <= 1'b0;
        end else begin
            cyc <= (cyc == 8'hC1) ? 8'h00 : cyc + 8'h01;
            if (cyc == 8'hC1) frm <= (frm == 5'h17) ? 5'h00 : frm + 5'h01;
            tx_valid <= (cyc != 8'hC1);
            tx_bit <= cyc[0];
            tx_mf_start <= (cyc == 8'h00) && (frm == 5'h00);
        end
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdv(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rdv(a, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask
    task automatic wf(input int n);
        repeat (n * 194) @(posedge core_clk);
    endtask
    // wait on the report busy flag, one look per frame
    task automatic poll(input logic b);
        int i;
        for (i = 0; i < 300; i++) begin
            rdv(`TMI_OFS_STATUS, s);
            if (s[2] === b) break;
            wf(1);
        end
        if (i == 300) begin
            $display("BAD busy expected %h seen %h", b, s[2]);
            n_errors++;
            complete_run;
        end
    endtask
    // one loop or override setting, judged on a whole frame
    task automatic cfg(input logic [7:0] md, lc, pt, mt, input logic fe,
                       input logic [7:0] ones, input string nm);
        wr(`TMI_OFS_MODE, md);
        wr(`TMI_OFS_LOOP_CTRL, lc);
        wr(`TMI_OFS_LOOP_PAT, pt);
        wr(`TMI_OFS_MAINT, mt);
        wf(3);
        chk({nm, "_fbit"}, {15'h0000, fe}, {15'h0000, f_last});
        chk(nm, {8'h00, ones}, {8'h00, ch_ones});
        $display("test %s done", nm);
    endtask
    // reflected frame check over octets 2 to 12
    function automatic logic [15:0] fcs();
        logic [15:0] c;
        c = `TMI_CRC_INIT;
        for (int i = 1; i < 12; i++)
            for (int b = 0; b < 8; b++)
                c = ((c[0] ^ ex[i][b]) ? `TMI_CRC_POLY : 16'h0000) ^ (c >> 1);
        return ~c;
    endfunction
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        rd(`TMI_OFS_BOM_CODE, `TMI_RST_BOM, "bom_reset");
        rd(`TMI_OFS_REPORT_CTRL, `TMI_RST_ZERO, "report_reset");
        wr(8'h10, 8'h5A);
        rd(8'h10, 8'h00, "unmapped");
        wr(`TMI_OFS_REPORT_CTRL, 8'h37);
        rd(`TMI_OFS_REPORT_CTRL, 8'h37, "report_ctrl");
        // first second: 7 code errors, one each of violation, framing, slip
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            ev_crc <= 1'b1;
            ev_lv <= (i == 0);
            ev_fb <= (i == 0);
            ev_sl <= (i == 0);
            @(posedge core_clk);
            {ev_crc, ev_lv, ev_fb, ev_sl} <= 4'h0;
        end
        $display("test registers done");
        wr(`TMI_OFS_MODE, 8'h03);
        wr(`TMI_OFS_BOM_CODE, 8'h15);
        wf(34);
        v = {1'b0, 6'h15, 1'b0, 8'hFF};
        f = 1'b0;
        for (int r = 0; r < 16; r++)
            if (dl_hist[127:112] == 16'({v, v} >> r)) f = 1'b1;
        chk("bom_pattern", 16'h0001, {15'h0000, f});
        wr(`TMI_OFS_BOM_CODE, 8'h3F);
        wf(34);
        chk("bom_off", 16'h0000, dl_hist[127:112]);
        wr(`TMI_OFS_MODE, 8'h01);
        wr(`TMI_OFS_BOM_CODE, 8'h15);
        wf(34);
        chk("bom_sf", 16'h0000, dl_hist[127:112]);
        wr(`TMI_OFS_BOM_CODE, 8'h3F);
        $display("test bit message done");
        cfg(8'h01, 8'h0F, 8'hFF, 8'h00, 1'b1, 8'hC0, "unframed");
        cfg(8'h01, 8'h05, 8'hC1, 8'h00, 1'b0, 8'h20, "framed");
        cfg(8'h01, 8'h0B, 8'hFF, 8'h00, 1'b0, 8'h60, "loop_off");
        cfg(8'h00, 8'h0F, 8'hFF, 8'h00, 1'b0, 8'h60, "e1_mode");
        cfg(8'h01, 8'h00, 8'h00, 8'h01, 1'b1, 8'hC0, "all_ones");
        cfg(8'h01, 8'h00, 8'h00, 8'h03, 1'b0, 8'h00, "all_zeros");
        rd(`TMI_OFS_MAINT, 8'h03, "maint");
        wr(`TMI_OFS_MAINT, 8'h00);
        wr(`TMI_OFS_MODE, 8'h03);
        rd(`TMI_OFS_MODE, 8'h03, "mode");
        // report from the first second
        ex = '{8'h7E, 8'h3A, 8'h01, 8'h03, 8'hCA, 8'hA9, 8'hCA, 8'hA9,
               8'hCA, 8'hA9, 8'hCA, 8'hA9, 8'h00, 8'h00};
        {ex[13], ex[12]} = fcs();
        poll(1'b1);
        poll(1'b0);
        rd(`TMI_OFS_STATUS, 8'h01, "status");
        wf(4);
        f = 1'b0;
        for (int i = 0; i <= 16; i++)
            if (dl_hist[i +: 8] == 8'h7E && dl_hist[i + 8 +: 8] == 8'h3A) begin
                f = 1'b1;
                for (int j = 0; j < 14; j++)
                    chk("octet", {8'h00, ex[j]}, {8'h00, dl_hist[i + 8 * j +: 8]});
            end
        chk("report_found", 16'h0001, {15'h0000, f});
        $display("test report done");
        // each toggle edge drops or repeats exactly one bit
        for (int k = 0; k < 2; k++) begin
            #1 d0 = n_in - n_out;
            wr(`TMI_OFS_MAINT, k == 0 ? 8'h04 : 8'h00);
            repeat (386) @(posedge core_clk);
            #1 d0 = n_in - n_out - d0;
            chk("shift", 16'h0001, {15'h0000, d0 == 1 || d0 == -1});
        end
        $display("test frame shift done");
        complete_run;
    end
endmodule
`default_nettype wire
